/* lwr_merge_defs.svh */
// constants for the right-part unaligned word load datapath
`ifndef LWR_MERGE_DEFS_SVH
`define LWR_MERGE_DEFS_SVH

`define LWRP_QUAD_W 128
`define LWRP_WORD_W 32
`define LWRP_REG_W 64
`define LWRP_IMM_W 16
`define LWRP_IDX_W 5
`define LWRP_PADDR_W 32
`define LWRP_LEN_W 2
`define LWRP_OFS_W 3
`define LWRP_LANE_POS 0
`define LWRP_WORD_POS 2
`define LWRP_SIGN_POS 31
`define LWRP_FULL_LEN 2'h3
`define LWRP_RST_ADDR 32'h0000_0000
`define LWRP_RST_REG 64'h0000_0000_0000_0000
`define LWRP_RST_QUAD 128'h0000_0000_0000_0000_0000_0000_0000_0000

`endif

/* lwr_merge_pkg.sv */
// types shared by the right-part unaligned word load datapath
package lwr_merge_pkg;

    typedef enum logic [1:0] {
        st_idle,
        st_xlat,
        st_mem,
        st_merge
    } lwrp_state_t;

endpackage : lwr_merge_pkg

/* lwr_byte_merge.sv */
// byte lane merge of the addressed memory word into the destination register
`timescale 1ns/1ps
`include "lwr_merge_defs.svh"

module lwr_byte_merge #(
    parameter bit KEEP_UPPER = 1'b1
) (
    // fetched data and old register
    input wire logic [`LWRP_QUAD_W-1:0] quad_i,
    input wire logic [`LWRP_REG_W-1:0] old_i,
    // address and byte order
    input wire logic [3:0] vaddr_lo_i,
    input wire logic big_endian_i,
    // results
    output logic [`LWRP_REG_W-1:0] merged_o,
    output logic [`LWRP_LEN_W-1:0] len_code_o
);

    logic [1:0] lane;
    logic [1:0] word;
    logic [`LWRP_WORD_W-1:0] mem_word;
    logic [`LWRP_WORD_W-1:0] low_word;
    logic full;

    // lane and word indices follow the cpu byte order
    assign lane = vaddr_lo_i[`LWRP_LANE_POS +: 2] ^ {2{big_endian_i}};
    assign word = vaddr_lo_i[`LWRP_WORD_POS +: 2] ^ {2{big_endian_i}};
    assign mem_word = quad_i[32*word +: 32];
    assign len_code_o = `LWRP_FULL_LEN - lane;
    assign full = (lane == 2'h0);

    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_lane
            logic [2:0] src;
            assign src = {1'b0, lane} + 3'(i);
            // a source beyond the top lane means this byte is not loaded
            assign low_word[8*i +: 8] = src[2] ? old_i[8*i +: 8]
                : mem_word[8*src[1:0] +: 8];
        end
    endgenerate

    always_comb begin
        if (full) begin
            merged_o = {{32{low_word[`LWRP_SIGN_POS]}}, low_word};
        end else if (KEEP_UPPER) begin
            merged_o = {old_i[`LWRP_REG_W-1:32], low_word};
        end else begin
            merged_o = {{32{low_word[`LWRP_SIGN_POS]}}, low_word};
        end
    end

endmodule : lwr_byte_merge

/* lwr_load_unit.sv */
// right-part unaligned word load: address, translation, fetch, merge, write
// Functional notes
// - address is sign-extended offset plus base low word
// - load one to four bytes within aligned word
// - addressed byte lands lowest, filling upward
// - unloaded low-word bytes keep old values
// - four bytes loaded: bit 31 fills upper half
// - bit 31 not loaded: upper half unchanged
// - fixed choice: keep or extend upper half
// - quad fetch, word and lane indices endian-xored
// - destination value forwarded, no gap needed
// - never raise an alignment exception
// - send length code and low physical bits
`timescale 1ns/1ps
`include "lwr_merge_defs.svh"

module lwr_load_unit #(
    parameter int PADDR_W = `LWRP_PADDR_W,
    parameter bit KEEP_UPPER = 1'b1
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // issue side
    input wire logic req_valid_i,
    input wire logic [`LWRP_REG_W-1:0] base_val_i,
    input wire logic [`LWRP_IMM_W-1:0] offset_i,
    input wire logic [`LWRP_IDX_W-1:0] dest_reg_i,
    input wire logic [`LWRP_REG_W-1:0] dest_old_i,
    input wire logic cpu_big_endian_sel_i,
    output logic req_ready_o,
    // writeback snoop for forwarding
    input wire logic fwd_valid_i,
    input wire logic [`LWRP_IDX_W-1:0] fwd_reg_i,
    input wire logic [`LWRP_REG_W-1:0] fwd_data_i,
    // address translation
    output logic xlat_req_o,
    output logic [`LWRP_WORD_W-1:0] xlat_vaddr_o,
    input wire logic xlat_ack_i,
    input wire logic [PADDR_W-1:0] xlat_paddr_i,
    input wire logic xlat_uncached_i,
    input wire logic xlat_fault_i,
    // data memory
    output logic mem_req_o,
    output logic [PADDR_W-1:0] mem_paddr_o,
    output logic [`LWRP_OFS_W-1:0] mem_byte_ofs_o,
    output logic [`LWRP_LEN_W-1:0] mem_len_o,
    output logic mem_uncached_o,
    output logic [`LWRP_WORD_W-1:0] mem_vaddr_o,
    input wire logic mem_ack_i,
    input wire logic [`LWRP_QUAD_W-1:0] mem_data_i,
    // register write and status
    output logic rf_we_o,
    output logic [`LWRP_IDX_W-1:0] rf_reg_o,
    output logic [`LWRP_REG_W-1:0] rf_data_o,
    output logic done_o,
    output logic fault_o,
    output logic align_err_o
);

    generate
        if (PADDR_W < 4) begin : g_bad_width
            $error("PADDR_W must be at least 4");
        end
        // the merge lanes assume a four-byte word inside a 64-bit register
        if (`LWRP_WORD_W != 32) begin : g_bad_word
            $error("word width must be 32");
        end
        if (`LWRP_REG_W != 64) begin : g_bad_reg
            $error("register width must be 64");
        end
        if (`LWRP_QUAD_W != 128) begin : g_bad_quad
            $error("quad width must be 128");
        end
        if (`LWRP_IMM_W != 16) begin : g_bad_imm
            $error("offset width must be 16");
        end
        if (`LWRP_LEN_W != 2 || `LWRP_OFS_W != 3) begin : g_bad_code
            $error("length code must be 2 bits and offset 3 bits");
        end
    endgenerate

    lwr_merge_pkg::lwrp_state_t state_r;
    logic [`LWRP_WORD_W-1:0] vaddr_r;
    logic [`LWRP_IDX_W-1:0] dest_reg_r;
    logic [`LWRP_REG_W-1:0] old_r;
    logic be_r;
    logic [`LWRP_QUAD_W-1:0] quad_r;
    logic [`LWRP_WORD_W-1:0] vaddr_nxt;
    logic [`LWRP_REG_W-1:0] old_live;
    logic [`LWRP_REG_W-1:0] merged;
    logic [`LWRP_LEN_W-1:0] len_code;
    logic take;

    // true when a writeback in flight targets the given register
    function automatic logic fwd_hit(
        input logic valid,
        input logic [`LWRP_IDX_W-1:0] wr_reg,
        input logic [`LWRP_IDX_W-1:0] rd_reg
    );
        fwd_hit = valid && (wr_reg == rd_reg);
    endfunction : fwd_hit

    // translation answered with a fault: the load is dropped, no write
    function automatic logic xlat_abort(
        input lwr_merge_pkg::lwrp_state_t st,
        input logic ack,
        input logic flt
    );
        xlat_abort = (st == lwr_merge_pkg::st_xlat) && ack && flt;
    endfunction : xlat_abort

    // translation answered cleanly: go on to the memory fetch
    function automatic logic xlat_pass(
        input lwr_merge_pkg::lwrp_state_t st,
        input logic ack,
        input logic flt
    );
        xlat_pass = (st == lwr_merge_pkg::st_xlat) && ack && !flt;
    endfunction : xlat_pass

    assign take = req_valid_i && req_ready_o;

    // only the low word of the base takes part in the sum
    assign vaddr_nxt = base_val_i[`LWRP_WORD_W-1:0]
        + {{16{offset_i[`LWRP_IMM_W-1]}}, offset_i};

    // newest value of the destination, even if written this very cycle
    always_comb begin
        if (fwd_hit(fwd_valid_i, fwd_reg_i, dest_reg_r)) begin
            old_live = fwd_data_i;
        end else begin
            old_live = old_r;
        end
    end

    lwr_byte_merge #(
        .KEEP_UPPER(KEEP_UPPER)
    ) u_merge (
        .quad_i(quad_r),
        .old_i(old_live),
        .vaddr_lo_i(vaddr_r[3:0]),
        .big_endian_i(be_r),
        .merged_o(merged),
        .len_code_o(len_code)
    );

    // sequencing
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            state_r <= lwr_merge_pkg::st_idle;
        end else begin
            case (state_r)
                lwr_merge_pkg::st_idle: begin
                    if (take) begin
                        state_r <= lwr_merge_pkg::st_xlat;
                    end
                end
                lwr_merge_pkg::st_xlat: begin
                    if (xlat_ack_i && xlat_fault_i) begin
                        state_r <= lwr_merge_pkg::st_idle;
                    end else if (xlat_ack_i) begin
                        state_r <= lwr_merge_pkg::st_mem;
                    end
                end
                lwr_merge_pkg::st_mem: begin
                    if (mem_ack_i) begin
                        state_r <= lwr_merge_pkg::st_merge;
                    end
                end
                lwr_merge_pkg::st_merge: begin
                    state_r <= lwr_merge_pkg::st_idle;
                end
                default: begin
                    state_r <= lwr_merge_pkg::st_idle;
                end
            endcase
        end
    end

    // ready only while idle; leaving idle drops it at once
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            req_ready_o <= 1'b0;
        end else if (take) begin
            req_ready_o <= 1'b0;
        end else if (state_r == lwr_merge_pkg::st_idle) begin
            req_ready_o <= 1'b1;
        end else if (state_r == lwr_merge_pkg::st_merge) begin
            req_ready_o <= 1'b1;
        end else if (xlat_abort(state_r, xlat_ack_i, xlat_fault_i)) begin
            req_ready_o <= 1'b1;
        end
    end

    // captured request
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            vaddr_r <= `LWRP_RST_ADDR;
            dest_reg_r <= '0;
            be_r <= 1'b0;
        end else if (take) begin
            vaddr_r <= vaddr_nxt;
            dest_reg_r <= dest_reg_i;
            be_r <= cpu_big_endian_sel_i;
        end
    end

    // destination copy, kept current by snooping writebacks in flight
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            old_r <= `LWRP_RST_REG;
        end else if (take) begin
            if (fwd_hit(fwd_valid_i, fwd_reg_i, dest_reg_i)) begin
                old_r <= fwd_data_i;
            end else begin
                old_r <= dest_old_i;
            end
        end else if (state_r != lwr_merge_pkg::st_idle) begin
            old_r <= old_live;
        end
    end

    // translation request
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            xlat_req_o <= 1'b0;
            xlat_vaddr_o <= `LWRP_RST_ADDR;
        end else if (take) begin
            xlat_req_o <= 1'b1;
            xlat_vaddr_o <= vaddr_nxt;
        end else if (xlat_ack_i) begin
            xlat_req_o <= 1'b0;
        end
    end

    // memory request: whole quad, endian-adjusted low address bits
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            mem_req_o <= 1'b0;
            mem_paddr_o <= '0;
            mem_byte_ofs_o <= '0;
            mem_len_o <= '0;
            mem_uncached_o <= 1'b0;
            mem_vaddr_o <= `LWRP_RST_ADDR;
        end else if (xlat_pass(state_r, xlat_ack_i, xlat_fault_i)) begin
            mem_req_o <= 1'b1;
            mem_paddr_o <= {xlat_paddr_i[PADDR_W-1:4], xlat_paddr_i[3:0] ^ {4{be_r}}};
            mem_byte_ofs_o <= xlat_paddr_i[2:0] ^ {3{be_r}};
            mem_len_o <= len_code;
            mem_uncached_o <= xlat_uncached_i;
            mem_vaddr_o <= vaddr_r;
        end else if (mem_ack_i) begin
            mem_req_o <= 1'b0;
        end
    end

    // returned quad
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            quad_r <= `LWRP_RST_QUAD;
        end else if (state_r == lwr_merge_pkg::st_mem && mem_ack_i) begin
            quad_r <= mem_data_i;
        end
    end

    // register write; a faulted load never reaches here
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            rf_we_o <= 1'b0;
            rf_reg_o <= '0;
            rf_data_o <= `LWRP_RST_REG;
        end else if (state_r == lwr_merge_pkg::st_merge) begin
            rf_we_o <= 1'b1;
            rf_reg_o <= dest_reg_r;
            rf_data_o <= merged;
        end else begin
            rf_we_o <= 1'b0;
        end
    end

    // completion and fault pulses
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            done_o <= 1'b0;
            fault_o <= 1'b0;
        end else begin
            done_o <= (state_r == lwr_merge_pkg::st_merge)
                || xlat_abort(state_r, xlat_ack_i, xlat_fault_i);
            fault_o <= xlat_abort(state_r, xlat_ack_i, xlat_fault_i);
        end
    end

    // any low address bits are legal for this load
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            align_err_o <= 1'b0;
        end else begin
            align_err_o <= 1'b0;
        end
    end

endmodule : lwr_load_unit

/* lwr_load_unit_asserts.sv */
// concurrent checks on the ports of the right-part word load unit
`timescale 1ns/1ps
module lwr_load_unit_asserts #(
    parameter int PADDR_W = 32
) (
    // clock, reset and issue
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic req_valid_i,
    input wire logic req_ready_o,
    input wire logic [63:0] base_val_i,
    input wire logic [15:0] offset_i,
    input wire logic cpu_big_endian_sel_i,
    // translation and memory
    input wire logic xlat_req_o,
    input wire logic xlat_ack_i,
    input wire logic [PADDR_W-1:0] xlat_paddr_i,
    input wire logic xlat_fault_i,
    input wire logic [31:0] xlat_vaddr_o,
    input wire logic mem_req_o,
    input wire logic [PADDR_W-1:0] mem_paddr_o,
    input wire logic [2:0] mem_byte_ofs_o,
    input wire logic [1:0] mem_len_o,
    input wire logic [31:0] mem_vaddr_o,
    input wire logic mem_ack_i,
    input wire logic [127:0] mem_data_i,
    // results
    input wire logic rf_we_o,
    input wire logic [63:0] rf_data_o,
    input wire logic done_o,
    input wire logic fault_o,
    input wire logic align_err_o
);
    logic be_a;
    logic be_m;
    logic [127:0] q_r;
    logic [1:0] b;
    logic [31:0] wd;
    // byte order is copied per stage, a new issue may start as the write lands
    always_ff @(posedge core_clk_i) if (req_valid_i && req_ready_o) be_a <= cpu_big_endian_sel_i;
    always_ff @(posedge core_clk_i) if (mem_req_o && mem_ack_i) be_m <= be_a;
    always_ff @(posedge core_clk_i) if (mem_req_o && mem_ack_i) q_r <= mem_data_i;
    assign b = mem_vaddr_o[1:0] ^ {2{be_m}};
    assign wd = q_r[32*(mem_vaddr_o[3:2] ^ {2{be_m}}) +: 32] >> (8*b);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence take_s; req_valid_i && req_ready_o; endsequence
    sequence xok_s; xlat_req_o && xlat_ack_i && !xlat_fault_i; endsequence
    sequence mtake_s; mem_req_o && mem_ack_i; endsequence
    chk_no_align: assert property (!align_err_o) else $error("alignment error raised");
    chk_addr_sum: assert property (take_s |=> xlat_req_o && xlat_vaddr_o ==
        $past(base_val_i[31:0] + {{16{offset_i[15]}}, offset_i})) else $error("bad vaddr");
    chk_paddr_xor: assert property (xok_s |=> mem_req_o &&
        mem_paddr_o[3:0] == ($past(xlat_paddr_i[3:0]) ^ {4{be_a}})) else $error("bad paddr");
    chk_ofs_len: assert property (xok_s |=> mem_byte_ofs_o == ($past(xlat_paddr_i[2:0])
        ^ {3{be_a}}) && mem_len_o == 2'h3 - (mem_vaddr_o[1:0] ^ {2{be_a}}))
        else $error("bad length or offset");
    chk_fault_abort: assert property (xlat_req_o && xlat_ack_i && xlat_fault_i |=>
        fault_o && done_o && !rf_we_o && !mem_req_o) else $error("fault not aborted");
    chk_write_due: assert property (mtake_s |-> ##[1:2] rf_we_o && done_o)
        else $error("write missing");
    chk_one_pulse: assert property (rf_we_o |=> !rf_we_o) else $error("write too long");
    chk_low_bytes: assert property (rf_we_o |->
        ((rf_data_o[31:0] ^ wd) & (32'hFFFF_FFFF >> (8*b))) == 32'h0000_0000)
        else $error("loaded bytes wrong");
    chk_sign_fill: assert property (rf_we_o && b == 2'h0 |->
        rf_data_o[63:32] == {32{rf_data_o[31]}}) else $error("upper half not extended");
endmodule : lwr_load_unit_asserts

bind lwr_load_unit lwr_load_unit_asserts #(.PADDR_W(PADDR_W)) lwr_load_unit_asserts_inst (.*);

/* lwr_mem_model.sv */
// far-side model: translation and quadword memory with set latency
`timescale 1ns/1ps
module lwr_mem_model (
    // clock, reset and test controls
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic [1:0] dly_i,
    input wire logic flt_i,
    input wire logic [127:0] quad_i,
    // unit side
    input wire logic xreq_i,
    input wire logic [31:0] xva_i,
    input wire logic mreq_i,
    output logic xack_o,
    output logic [31:0] xpa_o,
    output logic xunc_o,
    output logic xflt_o,
    output logic mack_o,
    output logic [127:0] mdata_o
);
    logic [1:0] xc_r;
    logic [1:0] mc_r;
    logic [31:0] pa_r;
    always_ff @(posedge core_clk_i) begin
        xc_r <= (sys_rst_i || !xreq_i || xack_o) ? 2'h0 : xc_r + 2'h1;
        xack_o <= !sys_rst_i && xreq_i && !xack_o && xc_r == dly_i;
        pa_r <= xva_i ^ 32'h4000_0000;
    end
    always_ff @(posedge core_clk_i) begin
        mc_r <= (sys_rst_i || !mreq_i || mack_o) ? 2'h0 : mc_r + 2'h1;
        mack_o <= !sys_rst_i && mreq_i && !mack_o && mc_r == dly_i;
    end
    // released lines show the inverse so a stale value never passes
    assign xpa_o = xack_o ? pa_r : ~pa_r;
    assign xunc_o = xack_o ? pa_r[4] : ~pa_r[4];
    assign xflt_o = xack_o ? flt_i : ~flt_i;
    assign mdata_o = mack_o ? quad_i : ~quad_i;
endmodule : lwr_mem_model

/* lwr_load_unit_test.sv */
// self-checking bench for the right-part word load unit
`timescale 1ns/1ps
module lwr_load_unit_test;
    logic core_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic req_valid_i = 1'b0;
    logic cpu_big_endian_sel_i = 1'b0;
    logic fwd_valid_i = 1'b0;
    logic flt = 1'b0;
    logic [63:0] base_val_i = 64'h0, dest_old_i = 64'h0, fwd_data_i = 64'h0;
    logic [15:0] offset_i = 16'h0;
    logic [4:0] dest_reg_i = 5'h0, fwd_reg_i = 5'h0;
    logic [1:0] dly = 2'h0;
    logic [127:0] quad = 128'h0;
    logic req_ready_o, xlat_req_o, xlat_ack_i, xlat_uncached_i, xlat_fault_i, mem_req_o;
    logic mem_uncached_o, mem_ack_i, rf_we_o, done_o, fault_o, align_err_o;
    logic [31:0] xlat_vaddr_o, xlat_paddr_i, mem_paddr_o, mem_vaddr_o;
    logic [2:0] mem_byte_ofs_o;
    logic [1:0] mem_len_o;
    logic [4:0] rf_reg_o;
    logic [63:0] rf_data_o;
    logic [127:0] mem_data_i;
    int err_count = 0;
    int n_tests = 0;
    int seed = 54611;

    always #4 core_clk_i = ~core_clk_i;

    lwr_load_unit lwr_load_unit_inst (.*);

    lwr_mem_model lwr_mem_model_inst (
        .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .dly_i(dly), .flt_i(flt),
        .quad_i(quad), .xreq_i(xlat_req_o), .xva_i(xlat_vaddr_o), .mreq_i(mem_req_o),
        .xack_o(xlat_ack_i), .xpa_o(xlat_paddr_i), .xunc_o(xlat_uncached_i),
        .xflt_o(xlat_fault_i), .mack_o(mem_ack_i), .mdata_o(mem_data_i)
    );

    // upper half kept on partial loads, extended on a full word
    function automatic logic [63:0] exp_val(input logic [63:0] old, input logic [127:0] q,
        input logic [31:0] va, input logic be);
        logic [1:0] b;
        logic [31:0] lo;
        b = va[1:0] ^ {2{be}};
        lo = (old[31:0] & ~(32'hFFFF_FFFF >> (8*b))) | (q[32*(va[3:2] ^ {2{be}}) +: 32] >> (8*b));
        exp_val = (b == 2'h0) ? {{32{lo[31]}}, lo} : {old[63:32], lo};
    endfunction : exp_val

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] s);
        n_tests++;
        if (s !== e) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    // hit selects whether the fresher value arrives on the forwarding path
    task automatic run(input logic [31:0] base, input logic [15:0] off, input logic be,
        input logic f, input logic hit);
        logic [63:0] old;
        logic [127:0] q;
        logic [31:0] va;
        logic [4:0] d;
        int n;
        @(posedge core_clk_i);
        va = base + {{16{off[15]}}, off};
        old = {$random(seed), $random(seed)};
        q = {$random(seed), $random(seed), $random(seed), $random(seed)};
        d = 5'($random(seed));
        req_valid_i <= 1'b1;
        base_val_i <= {32'($random(seed)), base};
        offset_i <= off;
        dest_reg_i <= d;
        cpu_big_endian_sel_i <= be;
        dest_old_i <= hit ? ~old : old;
        fwd_valid_i <= 1'b1;
        fwd_reg_i <= hit ? d : d ^ 5'h1;
        fwd_data_i <= hit ? old : ~old;
        flt <= f;
        dly <= va[5:4];
        quad <= q;
        n = 0;
        do begin
            @(negedge core_clk_i);
            n++;
        end while (req_ready_o !== 1'b1 && n < 40);
        @(posedge core_clk_i);
        req_valid_i <= 1'b0;
        fwd_valid_i <= 1'b0;
        do begin
            @(negedge core_clk_i);
            n++;
        end while (done_o !== 1'b1 && n < 40);
        if (n >= 40) begin
            err_count++;
            give_verdict();
        end
        chk("fault", f, fault_o);
        chk("write", !f, rf_we_o);
        chk("align", 1'b0, align_err_o);
        if (!f) begin
            chk("reg", d, rf_reg_o);
            chk("data", exp_val(old, q, va, be), rf_data_o);
            chk("len", 2'h3 - (va[1:0] ^ {2{be}}), mem_len_o);
            chk("vaddr", va, xlat_vaddr_o);
            chk("paddr", {va[31:4] ^ 28'h400_0000, va[3:0] ^ {4{be}}}, mem_paddr_o);
            chk("ofs", va[2:0] ^ {3{be}}, mem_byte_ofs_o);
            chk("uncached", va[4], mem_uncached_o);
            chk("memva", va, mem_vaddr_o);
        end
        $display("load at %h done", va);
    endtask : run

    initial begin
        repeat (12) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            run(($random(seed) & 32'hFFFF_FFFC) | i, i[0] ? 16'h8000 : 16'h7FFC, i[2], 1'b0, i[1]);
        end
        run($random(seed), 16'hFFFF, 1'b1, 1'b1, 1'b1);
        repeat (40) begin
            run($random(seed), 16'($random(seed)), 1'($random(seed)),
                ($random(seed) & 7) == 0, 1'($random(seed)));
        end
        give_verdict();
    end
endmodule : lwr_load_unit_test
